// *** bench/dfm_fault_manager_test.sv ***
// Self-checking bench for the drive fault manager
`timescale 1ns/1ps
`default_nettype none
module dfm_fault_manager_test;
    import dfm_pkg::*;
    logic core_clk = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, run_request = 1;
    logic [AW-1:0] reg_addr = 0;
    logic [DW-1:0] reg_wdata = 0, reg_rdata;
    logic [NCOND-1:0] fault_cond = 0;
    logic [3:0] key_req = 0;
    logic esc_key, stop_key, din_one, din_two, drive_enable, auto_start;
    logic flash_number, flash_indicator, fault_active;
    logic [7:0] disp_code;
    int err_total = 0, compares = 0, cyc = 0, starts = 0, n, s0;
    // Reference model: fault number and type of each source
    int code_q[$] = '{2, 3, 4, 5, 6, 7, 8, 12, 13};
    bit t1_q[$] = '{1, 0, 1, 1, 1, 1, 1, 0, 0};
    dfm_fault_manager #(.TICK_CYC(4)) u_dut (.core_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .fault_cond, .esc_key, .stop_key, .din_one, .din_two, .run_request,
        .drive_enable, .auto_start, .disp_code, .flash_number, .flash_indicator, .fault_active);
    dfm_panel_model u_panel (.core_clk, .rst_n, .key_req, .esc_key, .stop_key, .din_one, .din_two);
    // Clock
    initial forever #25 core_clk = ~core_clk;
    // Start pulses are counted and the run is cut short if it hangs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (auto_start === 1'b1) starts <= starts + 1;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (err_total == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk_reg(logic [15:0] got, logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: read %h, want %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_out(logic [15:0] got, logic [15:0] exp, string m);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s is %h, want %h", $time, m, got, exp);
        end
    endtask : chk_out
    task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
        @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(logic [AW-1:0] a, logic [15:0] e);
        @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk) reg_rd <= 1'b0;
        #1;
        chk_reg(reg_rdata, e);
    endtask : rd_chk
    task automatic key(int k);
        @(posedge core_clk) key_req <= 4'h1 << k;
        @(posedge core_clk) key_req <= 4'h0;
        repeat (8) @(posedge core_clk);
    endtask : key
    // Waits boundedly for fault state (w 0) or displayed number (w 1)
    task automatic wait_for(int w, logic [15:0] e);
        n = 0;
        while ((w == 0 ? 8'(fault_active) : disp_code) !== e[7:0] && n < 900) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk_out(w == 0 ? 8'(fault_active) : disp_code, e, "awaited output");
    endtask : wait_for
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hcc4d));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk(REG_DELAY, DELAY_RST);
        rd_chk(REG_TRIES, TRIES_RST);
        rd_chk(REG_LAST, CODE_NONE);
        rd_chk(4'h8 + 4'($urandom_range(7)), 16'h0000);
        // Each source: stop, number, record, type, held while present, stop key clears
        foreach (code_q[k]) begin
            @(posedge core_clk) fault_cond <= NCOND'(1) << k;
            wait_for(0, 1);
            chk_out(drive_enable, 0, "drive enable");
            chk_out(disp_code, code_q[k], "fault number");
            rd_chk(REG_LAST, code_q[k]);
            rd_chk(REG_STATUS, {10'h000, t1_q[k], 1'b0, 4'(k)});
            key(1);
            chk_out(fault_active, 1, "fault kept");
            fault_cond <= '0;
            key(1);
            wait_for(0, 0);
            chk_out(disp_code, 0, "number after clear");
        end
        // Flashing, escape acknowledge, clear by parameter write
        @(posedge core_clk) fault_cond[5] <= 1'b1;
        s0 = 0;
        repeat (45) @(posedge core_clk) s0 |= (flash_number & flash_indicator) === 1'b1;
        chk_out(s0, 1, "flashing");
        key(0);
        chk_out({flash_number, flash_indicator, disp_code}, 0, "acknowledged display");
        chk_out(fault_active, 1, "fault after escape");
        fault_cond <= '0;
        repeat ($urandom_range(2, 9)) @(posedge core_clk);
        wr(REG_FCLR, FCLR_B);
        wait_for(0, 0);
        // Stop mode above 3 and an unassigned input do not clear; input one does
        wr(REG_STOPMODE, 16'h0004);
        wr(REG_DI1FN, DIFN_CLEAR);
        wr(REG_TRIES, 16'h0002);
        wr(REG_DELAY, 16'h0002);
        @(posedge core_clk) fault_cond[2] <= 1'b1;
        wait_for(0, 1);
        fault_cond <= '0;
        key(1);
        key(3);
        chk_out(fault_active, 1, "stop mode 4");
        key(2);
        wait_for(0, 0);
        // Auto reset and restart of a type 1 fault
        s0 = starts;
        @(posedge core_clk) fault_cond[4] <= 1'b1;
        wait_for(0, 1);
        fault_cond <= '0;
        wait_for(0, 0);
        repeat (3) @(posedge core_clk);
        chk_out(starts - s0, 1, "start pulses");
        run_request <= 1'b0;
        repeat (220) @(posedge core_clk);
        rd_chk(REG_STATUS, 16'h0124);
        run_request <= 1'b1;
        repeat (220) @(posedge core_clk);
        rd_chk(REG_STATUS, 16'h0224);
        // Type 2 never auto clears; a parameter write of 1 clears it
        @(posedge core_clk) fault_cond[7] <= 1'b1;
        wait_for(0, 1);
        fault_cond <= '0;
        repeat (200) @(posedge core_clk);
        chk_out(fault_active, 1, "type 2 kept");
        wr(REG_FCLR, FCLR_A);
        wait_for(0, 0);
        // Lasting cause uses up the tries
        @(posedge core_clk) fault_cond[5] <= 1'b1;
        wait_for(1, 16'h0021);
        fault_cond <= '0;
        repeat (3) @(posedge core_clk);
        wr(REG_FCLR, FCLR_A);
        wait_for(0, 0);
        // Zero delay clears overvoltage with no restart
        wr(REG_DELAY, 16'h0000);
        s0 = starts;
        @(posedge core_clk) fault_cond[3] <= 1'b1;
        wait_for(0, 1);
        fault_cond <= '0;
        wait_for(0, 0);
        repeat (5) @(posedge core_clk);
        chk_out(starts - s0, 0, "start pulses");
        end_sim();
    end
endmodule : dfm_fault_manager_test
`default_nettype wire

// *** bench/dfm_panel_model.sv ***
// Keypad and terminal input stand-in driven by the bench
`timescale 1ns/1ps
`default_nettype none
module dfm_panel_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // One-cycle requests: escape, stop, toggle input one, toggle input two
    input wire logic [3:0] key_req,
    // Keypad and terminal pins
    output logic esc_key,
    output logic stop_key,
    output logic din_one,
    output logic din_two
);
    logic [2:0] hold;
    // key presses
    // Keys stay down for several cycles so the pin synchronisers see them
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold <= 3'h0;
            {stop_key, esc_key} <= 2'h0;
        end else if (key_req[1:0] != 2'h0) begin
            hold <= 3'h4;
            {stop_key, esc_key} <= key_req[1:0];
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end else begin
            {stop_key, esc_key} <= 2'h0;
        end
    end
    // input toggles
    // Terminal inputs act on edges, so each request flips the level
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {din_two, din_one} <= 2'h0;
        end else begin
            {din_two, din_one} <= {din_two, din_one} ^ key_req[3:2];
        end
    end
endmodule : dfm_panel_model
`default_nettype wire

// *** hw/dfm_fault_manager.sv ***
// Drive fault manager: detection, stop, classification, clearing, auto restart
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1 - Any fault stops the drive output until the fault is cleared.
// RQ2 - Each fault is type 1 (auto reset) or type 2 (manual only).
// RQ3 - Type 1 fault with tries above 0 starts delay countdown.
// RQ4 - At countdown end retry; if cause gone, clear and restart.
// RQ5 - After a successful auto reset the block issues its own start.
// RQ6 - Type 2 never clears automatically; clear needs the cause gone.
// RQ7 - While faulted, flash fault number and fault indicator.
// RQ8 - Escape acknowledges, stops flashing, keeps the fault latched.
// RQ9 - Most recent fault code is recorded for display.
// RQ10 - Stop key clears a resolved fault only with stop mode 0..3.
// RQ11 - Fault clear write of 1 or 2, or power cycle, clears.
// RQ12 - Edge on a digital input with function 7 clears.
// RQ13 - Delay 0: auto clear over/undervoltage, heatsink, no restart.
// RQ14 - Open auxiliary interlock raises F2, type 1.
// RQ15 - Excess bus ripple raises F3, type 2.
// RQ16 - Bus undervoltage raises F4, type 1.
// RQ17 - Bus overvoltage raises F5, type 1.
// RQ18 - Motor stall raises F6, type 1.
// RQ19 - Motor overload trip raises F7, type 1.
// RQ20 - Heatsink overtemperature raises F8, type 1.
// RQ21 - Hardware overcurrent raises F12, type 2.
// RQ22 - Ground fault raises F13, type 2.
// RQ23 - Exhausted retries raise F33, cleared manually.
// RQ24 - Retries counted; reloaded on manual clear or fault-free run.
// RQ25 - Any clear ends flashing and releases the stop.
module dfm_fault_manager #(
    parameter int TICK_CYC = dfm_pkg::TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [dfm_pkg::AW-1:0] reg_addr,
    input wire logic [dfm_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dfm_pkg::DW-1:0] reg_rdata,
    // Fault condition pins
    input wire logic [dfm_pkg::NCOND-1:0] fault_cond,
    // Keypad and digital input pins
    input wire logic esc_key,
    input wire logic stop_key,
    input wire logic din_one,
    input wire logic din_two,
    // Run request from the drive controller
    input wire logic run_request,
    // Drive control and display
    output logic drive_enable,
    output logic auto_start,
    output logic [7:0] disp_code,
    output logic flash_number,
    output logic flash_indicator,
    output logic fault_active
);
    import dfm_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Fault number shown for each source index
    function automatic logic [7:0] idx_code(input logic [3:0] ix);
        case (ix)
            // RQ14 aux interlock
            IX_AUX: idx_code = 8'h02;
            // RQ15 ripple loss
            IX_RIPPLE: idx_code = 8'h03;
            // RQ16 undervoltage
            IX_UNDER: idx_code = 8'h04;
            // RQ17 overvoltage
            IX_OVER: idx_code = 8'h05;
            // RQ18 motor stall
            IX_STALL: idx_code = 8'h06;
            // RQ19 motor overload
            IX_OVL: idx_code = 8'h07;
            // RQ20 heatsink overtemp
            IX_HEAT: idx_code = 8'h08;
            // RQ21 hw overcurrent
            IX_HWOC: idx_code = 8'h0C;
            // RQ22 ground fault
            IX_GND: idx_code = 8'h0D;
            // RQ23 tries exhausted
            IX_TRIES: idx_code = 8'h21;
            default: idx_code = CODE_NONE;
        endcase
    endfunction : idx_code

    // RQ2 type classification
    function automatic logic idx_type1(input logic [3:0] ix);
        case (ix)
            IX_AUX, IX_UNDER, IX_OVER, IX_STALL, IX_OVL, IX_HEAT: idx_type1 = 1'b1;
            default: idx_type1 = 1'b0;
        endcase
    endfunction : idx_type1

    // Lowest index wins when several sources trip together
    function automatic logic [3:0] first_idx(input logic [NCOND-1:0] v);
        first_idx = IX_TRIES;
        for (int i = NCOND - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_idx = 4'(i);
            end
        end
    endfunction : first_idx

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NCOND-1:0] cond_m;
    logic [NCOND-1:0] cond;
    logic [3:0] key_m;
    logic [3:0] key_s;
    logic [3:0] key_d;
    // Two stages before any logic looks at the pins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_m <= '0;
            cond <= '0;
            key_m <= 4'h0;
            key_s <= 4'h0;
            key_d <= 4'h0;
        end else if (ce) begin
            cond_m <= fault_cond;
            cond <= cond_m;
            key_m <= {din_two, din_one, stop_key, esc_key};
            key_s <= key_m;
            key_d <= key_s;
        end
    end
    logic esc_rise;
    logic stop_rise;
    logic [1:0] din_tog;
    assign esc_rise = key_s[0] & ~key_d[0];
    assign stop_rise = key_s[1] & ~key_d[1];
    // Any change on a digital input counts as a cycle of that input
    assign din_tog = key_s[3:2] ^ key_d[3:2];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] tries_set;
    logic [7:0] delay_set;
    logic [2:0] stop_mode;
    logic [3:0] di1_fn;
    logic [3:0] di2_fn;
    logic param_clr;
    // Settings written by software
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tries_set <= TRIES_RST;
            delay_set <= DELAY_RST;
            stop_mode <= STOPMODE_RST;
            di1_fn <= DIFN_RST;
            di2_fn <= DIFN_RST;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                REG_TRIES: tries_set <= reg_wdata[7:0];
                REG_DELAY: delay_set <= reg_wdata[7:0];
                REG_STOPMODE: stop_mode <= reg_wdata[2:0];
                REG_DI1FN: di1_fn <= reg_wdata[3:0];
                REG_DI2FN: di2_fn <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end
    // RQ11 clear parameter write
    assign param_clr = reg_wr && reg_addr == REG_FCLR &&
        (reg_wdata[1:0] == FCLR_A || reg_wdata[1:0] == FCLR_B) && reg_wdata[DW-1:2] == '0;

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    logic [$clog2(TICK_CYC)-1:0] pre_cnt;
    logic tick;
    // Tick prescaler; delay and blink run in ticks to keep counters small
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= pre_cnt == $bits(pre_cnt)'(TICK_CYC - 1);
            if (pre_cnt == $bits(pre_cnt)'(TICK_CYC - 1)) begin
                pre_cnt <= '0;
            end else begin
                pre_cnt <= pre_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Fault state machine
    // ------------------------------------------------------------
    dfm_state_e state;
    logic [3:0] fidx;
    logic [7:0] timer;
    logic [7:0] tries_left;
    logic [7:0] good_cnt;
    logic gone;
    logic manual_clr;
    // Cause gone: own source quiet; F33 needs every source quiet
    assign gone = (fidx == IX_TRIES) ? ~|cond : ~cond[fidx];
    // RQ10 stop key
    // RQ12 digital input clear
    assign manual_clr = (stop_rise && stop_mode <= STOPMODE_CLR_MAX) || param_clr ||
        (din_tog[0] && di1_fn == DIFN_CLEAR) || (din_tog[1] && di2_fn == DIFN_CLEAR);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN;
            fidx <= IX_TRIES;
            timer <= 8'h00;
            tries_left <= TRIES_RST;
            auto_start <= 1'b0;
        end else if (ce) begin
            auto_start <= 1'b0;
            case (state)
                ST_RUN: begin
                    // RQ24 reload after fault-free run
                    if (good_cnt == GOOD_RUN_TICKS) begin
                        tries_left <= tries_set;
                    end
                    if (|cond) begin
                        fidx <= first_idx(cond);
                        timer <= delay_set;
                        // RQ3 start countdown
                        if (idx_type1(first_idx(cond)) && tries_left != 8'h00) begin
                            state <= ST_DELAY;
                        end else begin
                            state <= ST_HOLD;
                        end
                    end
                end
                ST_DELAY: begin
                    if (manual_clr && gone) begin
                        state <= ST_RUN;
                        tries_left <= tries_set;
                    end else if (timer != 8'h00) begin
                        if (tick) begin
                            timer <= timer - 1'b1;
                        end
                    end else if (delay_set == 8'h00) begin
                        // RQ13 zero delay: a retry every cycle would burn the tries, so wait for the cause
                        if (fidx != IX_UNDER && fidx != IX_OVER && fidx != IX_HEAT) begin
                            state <= ST_HOLD;
                        end else if (gone) begin
                            state <= ST_RUN;
                        end
                    end else begin
                        // RQ24 count the attempt
                        tries_left <= tries_left - 1'b1;
                        if (gone) begin
                            // RQ4 reset fault
                            // RQ5 own start command
                            state <= ST_RUN;
                            auto_start <= 1'b1;
                        end else if (tries_left == 8'h01) begin
                            // RQ23 retries exhausted
                            fidx <= IX_TRIES;
                            state <= ST_HOLD;
                        end else begin
                            timer <= delay_set;
                        end
                    end
                end
                ST_HOLD: begin
                    // RQ6 manual clear only, cause gone
                    if (manual_clr && gone) begin
                        state <= ST_RUN;
                        tries_left <= tries_set;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // Fault-free run time for the retry reload
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            good_cnt <= 8'h00;
        end else if (ce) begin
            if (state != ST_RUN || !run_request || |cond) begin
                good_cnt <= 8'h00;
            end else if (tick && good_cnt != GOOD_RUN_TICKS) begin
                good_cnt <= good_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Drive stop and recorded code
    // ------------------------------------------------------------
    logic [7:0] last_code;
    // RQ1 stop on any fault
    // RQ25 release on clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_enable <= 1'b0;
            fault_active <= 1'b0;
        end else if (ce) begin
            drive_enable <= state == ST_RUN && !(|cond);
            fault_active <= state != ST_RUN;
        end
    end
    // RQ9 most recent fault
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_code <= CODE_NONE;
        end else if (ce) begin
            if (state == ST_RUN && |cond) begin
                last_code <= idx_code(first_idx(cond));
            end else if (state == ST_DELAY && timer == 8'h00 && delay_set != 8'h00 && !gone &&
                tries_left == 8'h01) begin
                last_code <= idx_code(IX_TRIES);
            end
        end
    end

    // ------------------------------------------------------------
    // Keypad indication
    // ------------------------------------------------------------
    logic acked;
    logic [3:0] blink_cnt;
    logic blink;
    // RQ8 escape acknowledge; a fresh fault wins over the key
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acked <= 1'b0;
        end else if (ce) begin
            if (state == ST_RUN) begin
                acked <= 1'b0;
            end else if (esc_rise) begin
                acked <= 1'b1;
            end
        end
    end
    // Blink phase, half period in ticks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt <= 4'h0;
            blink <= 1'b0;
        end else if (ce && tick) begin
            if (blink_cnt == BLINK_TICKS - 1'b1) begin
                blink_cnt <= 4'h0;
                blink <= ~blink;
            end else begin
                blink_cnt <= blink_cnt + 1'b1;
            end
        end
    end
    // RQ7 flash number and indicator
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_number <= 1'b0;
            flash_indicator <= 1'b0;
            disp_code <= CODE_NONE;
        end else if (ce) begin
            flash_number <= state != ST_RUN && !acked && blink;
            flash_indicator <= state != ST_RUN && !acked && blink;
            disp_code <= (state != ST_RUN && !acked) ? idx_code(fidx) : CODE_NONE;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    REG_TRIES: reg_rdata <= {8'h00, tries_set};
                    REG_DELAY: reg_rdata <= {8'h00, delay_set};
                    REG_STOPMODE: reg_rdata <= {13'h0000, stop_mode};
                    REG_DI1FN: reg_rdata <= {12'h000, di1_fn};
                    REG_DI2FN: reg_rdata <= {12'h000, di2_fn};
                    REG_STATUS: reg_rdata <= {tries_left, 2'h0, 1'(idx_type1(fidx)), acked, fidx};
                    REG_LAST: reg_rdata <= {8'h00, last_code};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_stop;
        @(posedge core_clk) disable iff (!rst_n) ce && |cond |=> !drive_enable;
    endproperty
    a_stop: assert property (p_stop) else $error("drive not stopped on fault"); // RQ1
    property p_delay;
        @(posedge core_clk) disable iff (!rst_n)
            ce && state == ST_RUN && |cond && idx_type1(first_idx(cond)) && tries_left != 8'h00
            |=> state == ST_DELAY;
    endproperty
    a_delay: assert property (p_delay) else $error("countdown not started"); // RQ3
    property p_start;
        @(posedge core_clk) disable iff (!rst_n)
            auto_start |-> $past(state) == ST_DELAY && state == ST_RUN;
    endproperty
    a_start: assert property (p_start) else $error("start outside retry"); // RQ5
    property p_type2;
        @(posedge core_clk) disable iff (!rst_n)
            ce && state == ST_HOLD && !manual_clr |=> state == ST_HOLD;
    endproperty
    a_type2: assert property (p_type2) else $error("hold left without clear"); // RQ6
    property p_flash;
        @(posedge core_clk) disable iff (!rst_n)
            ce && state == ST_RUN |=> !flash_number && !flash_indicator && disp_code == CODE_NONE;
    endproperty
    a_flash: assert property (p_flash) else $error("flashing while healthy"); // RQ7
    property p_ack;
        @(posedge core_clk) disable iff (!rst_n)
            ce && esc_rise && state != ST_RUN ##1 ce && state != ST_RUN |=> !flash_number;
    endproperty
    a_ack: assert property (p_ack) else $error("flash after escape"); // RQ8
    property p_last;
        @(posedge core_clk) disable iff (!rst_n)
            ce && state == ST_RUN && cond[IX_HWOC] && !(|cond[6:0]) |=> last_code == 8'h0C;
    endproperty
    a_last: assert property (p_last) else $error("last code not recorded"); // RQ9
    property p_stopmode;
        @(posedge core_clk) disable iff (!rst_n)
            ce && state == ST_HOLD && stop_rise && stop_mode > STOPMODE_CLR_MAX && !param_clr
            && din_tog == 2'b00 |=> state == ST_HOLD;
    endproperty
    a_stopmode: assert property (p_stopmode) else $error("stop cleared in wrong mode"); // RQ10
    property p_param;
        @(posedge core_clk) disable iff (!rst_n)
            ce && state != ST_RUN && param_clr && gone |=> state == ST_RUN ##1 fault_active == 1'b0;
    endproperty
    a_param: assert property (p_param) else $error("clear write ignored"); // RQ11
    c_auto: cover property (@(posedge core_clk) disable iff (!rst_n) auto_start);
    c_tries: cover property (@(posedge core_clk) disable iff (!rst_n) state == ST_HOLD && fidx == IX_TRIES);
    c_manual: cover property (@(posedge core_clk) disable iff (!rst_n) state == ST_HOLD ##1 state == ST_RUN);
endmodule : dfm_fault_manager
`default_nettype wire

// *** hw/dfm_pkg.sv ***
// Constants, register map and fault encodings for the drive fault manager
package dfm_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
    localparam logic [3:0] BLINK_TICKS = 4'h5;
    localparam logic [7:0] GOOD_RUN_TICKS = 8'h32;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int AW = 4;
    localparam int DW = 16;
    localparam logic [AW-1:0] REG_TRIES = 4'h0;
    localparam logic [AW-1:0] REG_DELAY = 4'h1;
    localparam logic [AW-1:0] REG_FCLR = 4'h2;
    localparam logic [AW-1:0] REG_STOPMODE = 4'h3;
    localparam logic [AW-1:0] REG_DI1FN = 4'h4;
    localparam logic [AW-1:0] REG_DI2FN = 4'h5;
    localparam logic [AW-1:0] REG_STATUS = 4'h6;
    localparam logic [AW-1:0] REG_LAST = 4'h7;
    localparam logic [7:0] TRIES_RST = 8'h00;
    localparam logic [7:0] DELAY_RST = 8'h0A;
    localparam logic [2:0] STOPMODE_RST = 3'h0;
    localparam logic [2:0] STOPMODE_CLR_MAX = 3'h3;
    localparam logic [3:0] DIFN_RST = 4'h0;
    localparam logic [3:0] DIFN_CLEAR = 4'h7;
    localparam logic [1:0] FCLR_A = 2'h1;
    localparam logic [1:0] FCLR_B = 2'h2;
    // ------------------------------------------------------------
    // Fault sources, index order is also priority order
    // ------------------------------------------------------------
    localparam int NCOND = 9;
    localparam logic [3:0] IX_AUX = 4'h0;
    localparam logic [3:0] IX_RIPPLE = 4'h1;
    localparam logic [3:0] IX_UNDER = 4'h2;
    localparam logic [3:0] IX_OVER = 4'h3;
    localparam logic [3:0] IX_STALL = 4'h4;
    localparam logic [3:0] IX_OVL = 4'h5;
    localparam logic [3:0] IX_HEAT = 4'h6;
    localparam logic [3:0] IX_HWOC = 4'h7;
    localparam logic [3:0] IX_GND = 4'h8;
    localparam logic [3:0] IX_TRIES = 4'h9;
    localparam logic [7:0] CODE_NONE = 8'h00;
    typedef enum logic [1:0] {ST_RUN, ST_DELAY, ST_HOLD} dfm_state_e;
endpackage : dfm_pkg
